// ---- rtl/ret_rot_pkg.sv ----
// constants for the return and rotate execution block
package ret_rot_pkg;
   localparam int WORD_W = 14;            // program word width
   localparam int DATA_W = 8;             // data path width
   localparam int PC_W = 13;              // program counter width
   localparam int FADDR_W = 7;            // file address width
   localparam int STACK_DEPTH = 8;        // return stack entries
   localparam int SP_W = 3;               // stack pointer width
   // opcode patterns; OP_RETURN is compared whole, the others under masks
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [13:0] OP_RETLIT_MASK = 14'h3C00;
   localparam logic [13:0] OP_RETLIT = 14'h3400;
   localparam logic [13:0] OP_ROTL_MASK = 14'h3F00;
   localparam logic [13:0] OP_ROTL = 14'h0D00;
   localparam logic [13:0] OP_CALL_MASK = 14'h3800;
   localparam logic [13:0] OP_CALL = 14'h2000;
   // field positions
   localparam int DEST_BIT = 7;           // destination select bit
   localparam int LIT_LSB = 0;            // immediate field low bit
   localparam int FADDR_LSB = 0;          // file address low bit
   // cycle counts
   localparam int RET_CYCLES = 2;         // both return forms
   localparam int ROT_CYCLES = 1;         // rotate-left
   // reset values
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [12:0] PC_RST = 13'h0000;
   typedef enum logic [0:0] {
      ST_EXEC = 1'b0,                      // executing fetched word
      ST_FLUSH = 1'b1                      // refill cycle after a return
   } phase_type;
endpackage : ret_rot_pkg

// ---- rtl/ret_stack.sv ----
// hardware return stack with registered head output
`timescale 1ns/10ps
`default_nettype none
module ret_stack (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // push and pop
   input wire logic push,
   input wire logic [ret_rot_pkg::PC_W-1:0] push_addr,
   input wire logic pop,
   // registered head
   output logic [ret_rot_pkg::PC_W-1:0] stack_head
);
   import ret_rot_pkg::*;
   typedef struct packed {
      logic [STACK_DEPTH-1:0][PC_W-1:0] mem; // circular entries
      logic [SP_W-1:0] sp;                   // next free slot
      logic [PC_W-1:0] head;                 // top entry copy
   } stk_type;
   stk_type s_r, s_nxt;
   ////////////////////////////////////////////////////////////////
   // circular stack: overflow wraps silently, like the real core
   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.sp] = push_addr;
         s_nxt.sp = s_r.sp + 3'h1;
         s_nxt.head = push_addr;
      end else if (pop) begin
         s_nxt.sp = s_r.sp - 3'h1;
         s_nxt.head = s_r.mem[s_r.sp - 3'h2];
      end
   end
   // one register for all stack state
   always_ff @(posedge clock) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign stack_head = s_r.head;
endmodule : ret_stack
`default_nettype wire

// ---- rtl/return_and_rotate_exec.sv ----
// execution of return, return-with-literal and rotate-left
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // instruction word from fetch
   input wire logic [ret_rot_pkg::WORD_W-1:0] instr,
   input wire logic instr_valid,
   // call push from the rest of the core
   input wire logic [ret_rot_pkg::PC_W-1:0] pc_in,
   // file register read data and flags in
   input wire logic [ret_rot_pkg::DATA_W-1:0] file_rdata,
   input wire logic carry_in,
   // file register write back
   output logic [ret_rot_pkg::FADDR_W-1:0] file_addr,
   output logic [ret_rot_pkg::DATA_W-1:0] file_wdata,
   output logic file_we,
   // architectural results
   output logic [ret_rot_pkg::DATA_W-1:0] acc,
   output logic carry_out,
   output logic carry_we,
   output logic [ret_rot_pkg::PC_W-1:0] pc_load,
   output logic pc_load_en,
   output logic flush
);
   import ret_rot_pkg::*;
   ////////////////////////////////////////////////////////////////
   // decode helpers
   function automatic logic is_match(input logic [13:0] w, input logic [13:0] m,
                                     input logic [13:0] p);
      is_match = (w & m) == p;
   endfunction : is_match
   typedef struct packed {
      phase_type phase;              // exec or refill
      logic [DATA_W-1:0] acc;        // accumulator copy
      logic [FADDR_W-1:0] faddr;     // write-back address
      logic [DATA_W-1:0] fdata;      // write-back data
      logic fwe;                     // write-back strobe
      logic cout;                    // new carry
      logic cwe;                     // carry update strobe
      logic [PC_W-1:0] pcl;          // pc reload value
      logic pcl_en;                  // pc reload strobe
   } st_type;
   st_type st_r, st_nxt;
   logic [PC_W-1:0] stack_head;      // registered top of stack
   logic go; // word accepted this cycle
   logic do_ret; // plain return decoded
   logic do_retlit; // return with literal decoded
   logic do_rot; // rotate-left decoded
   logic do_call; // call word, pushes pc_in
   logic [DATA_W-1:0] rot_val; // rotated file value
   logic [FADDR_W-1:0] f_field; // file address field
   logic d_field; // destination select
   logic [DATA_W-1:0] k_field; // literal field
   ////////////////////////////////////////////////////////////////
   // field extraction
   // fields are cut from every word; only the decoded strobes give them meaning
   assign f_field = instr[FADDR_LSB +: FADDR_W];
   assign d_field = instr[DEST_BIT];
   assign k_field = instr[LIT_LSB +: DATA_W];
   // words arriving during the refill cycle are discarded: the fetch behind a
   // return was made from the old pc, so letting it run would execute a word
   // that the program never reaches
   assign go = instr_valid && (st_r.phase == ST_EXEC);
   assign do_ret = go && (instr == OP_RETURN);
   assign do_retlit = go && is_match(instr, OP_RETLIT_MASK, OP_RETLIT);
   assign do_rot = go && is_match(instr, OP_ROTL_MASK, OP_ROTL);
   assign do_call = go && is_match(instr, OP_CALL_MASK, OP_CALL);
   // old carry into bit 0, bit 7 out to carry
   assign rot_val = {file_rdata[DATA_W-2:0], carry_in};
   ////////////////////////////////////////////////////////////////
   // return stack; its head is a register, so the value popped by a return
   // is the latest address pushed and not yet popped, already in the register when the return is decoded
   ret_stack u_stack (
      .clock(clock),
      .rst(rst),
      .push(do_call),
      .push_addr(pc_in),
      .pop(do_ret || do_retlit),
      .stack_head(stack_head)
   );
   ////////////////////////////////////////////////////////////////
   // next-state logic; strobes are one-cycle pulses
   always_comb begin
      st_nxt = st_r;
      st_nxt.fwe = 1'b0;
      st_nxt.cwe = 1'b0;
      st_nxt.pcl_en = 1'b0;
      case (st_r.phase)
         ST_EXEC: begin
            if (do_ret || do_retlit) begin
               // pc from head, then one lost refill cycle
               st_nxt.pcl = stack_head;
               st_nxt.pcl_en = 1'b1;
               st_nxt.phase = ST_FLUSH;
               if (do_retlit) begin
                  st_nxt.acc = k_field;
               end
            end else if (do_rot) begin
               // single cycle, carry only flag
               st_nxt.cout = file_rdata[DATA_W-1];
               st_nxt.cwe = 1'b1;
               if (d_field) begin
                  st_nxt.faddr = f_field;
                  st_nxt.fdata = rot_val;
                  st_nxt.fwe = 1'b1;
               end else begin
                  st_nxt.acc = rot_val;
               end
            end
         end
         ST_FLUSH: begin
            // refill cycle: nothing is decoded, strobes stay low
            st_nxt.phase = ST_EXEC;
         end
         default: begin
            // unreachable with a one-bit phase; recover to execution
            st_nxt.phase = ST_EXEC;
         end
      endcase
   end
   // single state register
   always_ff @(posedge clock) begin
      if (rst) begin
         st_r <= '{phase: ST_EXEC, acc: ACC_RST, faddr: '0, fdata: '0, fwe: 1'b0,
                   cout: 1'b0, cwe: 1'b0, pcl: PC_RST, pcl_en: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////
   // outputs, all from flip-flops
   // flush is decoded from the phase register alone, so it carries no glitch
   assign acc = st_r.acc;
   assign file_addr = st_r.faddr;
   assign file_wdata = st_r.fdata;
   assign file_we = st_r.fwe;
   assign carry_out = st_r.cout;
   assign carry_we = st_r.cwe;
   assign pc_load = st_r.pcl;
   assign pc_load_en = st_r.pcl_en;
   assign flush = (st_r.phase == ST_FLUSH);
   ////////////////////////////////////////////////////////////////
   // checks
   sequence ret_issued_s;
      do_ret || do_retlit;
   endsequence
   sequence refill_s;
      pc_load_en && flush ##1 !flush;
   endsequence
   sequence quiet_s;
      !file_we && !carry_we && !pc_load_en;
   endsequence
   retlit_acc_a: assert property (@(posedge clock) disable iff (rst)
      do_retlit |=> (acc == $past(k_field)) && !carry_we)
      else $error("accumulator not loaded with literal");
   ret_two_cycle_a: assert property (@(posedge clock) disable iff (rst)
      ret_issued_s |=> refill_s)
      else $error("return did not take two cycles");
   ret_pc_a: assert property (@(posedge clock) disable iff (rst)
      ret_issued_s |=> pc_load == $past(stack_head))
      else $error("pc not loaded from stack head");
   rot_carry_a: assert property (@(posedge clock) disable iff (rst)
      do_rot |=> carry_we && carry_out == $past(file_rdata[7]))
      else $error("rotate carry wrong");
   rot_dest_f_a: assert property (@(posedge clock) disable iff (rst)
      do_rot && d_field |=> file_we && file_wdata == $past(rot_val) && $stable(acc))
      else $error("rotate to file wrong");
   rot_dest_w_a: assert property (@(posedge clock) disable iff (rst)
      do_rot && !d_field |=> !file_we && acc == $past(rot_val))
      else $error("rotate to accumulator wrong");
   rot_one_cycle_a: assert property (@(posedge clock) disable iff (rst)
      do_rot |=> !flush && !pc_load_en)
      else $error("rotate took extra cycle");
   rot_addr_a: assert property (@(posedge clock) disable iff (rst)
      do_rot && d_field |=> file_addr == $past(instr[6:0]))
      else $error("file address field wrong");
   // the refill cycle executes nothing, whatever word is offered
   refill_drop_a: assert property (@(posedge clock) disable iff (rst)
      flush |=> quiet_s)
      else $error("word executed in refill cycle");
   // only one cycle is lost per return
   refill_once_a: assert property (@(posedge clock) disable iff (rst)
      flush |=> !flush)
      else $error("refill lasted more than one cycle");
   // a return of either form touches no flag and no file register
   ret_no_flag_a: assert property (@(posedge clock) disable iff (rst)
      ret_issued_s |=> !carry_we && !file_we)
      else $error("return changed a flag or file register");
   // a plain return has no operand, so the accumulator holds
   ret_acc_keep_a: assert property (@(posedge clock) disable iff (rst)
      do_ret |=> $stable(acc))
      else $error("plain return changed accumulator");
   // the pc is reloaded only by a return
   pc_src_a: assert property (@(posedge clock) disable iff (rst)
      !(do_ret || do_retlit) |=> !pc_load_en)
      else $error("pc reloaded without a return");
   // the accumulator moves only for a literal return or a rotate into it
   acc_hold_a: assert property (@(posedge clock) disable iff (rst)
      !(do_retlit || (do_rot && !d_field)) |=> $stable(acc))
      else $error("accumulator changed unexpectedly");
   // the file register is written only by a rotate with destination one
   file_we_src_a: assert property (@(posedge clock) disable iff (rst)
      !(do_rot && d_field) |=> !file_we)
      else $error("file register written unexpectedly");
   // carry is the only flag here and only a rotate updates it
   carry_src_a: assert property (@(posedge clock) disable iff (rst)
      !do_rot |=> !carry_we)
      else $error("carry updated without a rotate");
   // a word that is not offered, or not decoded, does nothing
   idle_quiet_a: assert property (@(posedge clock) disable iff (rst)
      !(do_ret || do_retlit || do_rot) |=> !file_we && !carry_we && !pc_load_en)
      else $error("unknown or absent word had an effect");
endmodule : return_and_rotate_exec
`default_nettype wire

// ---- tb/test_return_and_rotate_exec.sv ----
// self-checking bench for the return and rotate execution block
`timescale 1ns/10ps
`default_nettype none
module test_return_and_rotate_exec;
   import ret_rot_pkg::*;
   // inputs, all driven by the bench
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [WORD_W-1:0] instr = 14'h0000;
   logic instr_valid = 1'b0;
   logic [PC_W-1:0] pc_in = 13'h0000;
   logic [DATA_W-1:0] file_rdata = 8'h00;
   logic carry_in = 1'b0;
   // outputs seen from the block
   logic [FADDR_W-1:0] file_addr;
   logic [DATA_W-1:0] file_wdata, acc;
   logic file_we, carry_out, carry_we, pc_load_en, flush;
   logic [PC_W-1:0] pc_load;
   int fails = 0; // mismatches
   int n_tests = 0; // comparisons
   return_and_rotate_exec return_and_rotate_exec_i (.clock(clock), .rst(rst), .instr(instr),
      .instr_valid(instr_valid), .pc_in(pc_in), .file_rdata(file_rdata), .carry_in(carry_in),
      .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we), .acc(acc),
      .carry_out(carry_out), .carry_we(carry_we), .pc_load(pc_load),
      .pc_load_en(pc_load_en), .flush(flush));
   // 50 ns clock
   initial begin
      forever #25 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // compare with case equality so an unknown never matches
   task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // present one word at a rising edge; it is taken at the next one
   task step(input logic [13:0] w, input logic v);
      @(posedge clock);
      instr <= w;
      instr_valid <= v;
   endtask : step
   // a call word pushes the return address
   task push(input logic [12:0] a);
      step(14'h2100, 1'b1);
      pc_in <= a;
   endtask : push
   task end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   ////////////////////////////////////////////////////////////////////////////////
   // literal return; a rotate offered in the refill cycle must be dropped
   task test_retlit;
      push(13'h1234);
      step(14'h3455, 1'b1);
      step(14'h0D85, 1'b1);
      #1 check("acc", acc, 16'h0055);
      check("pc_load", pc_load, 16'h1234);
      check("pc_load_en", pc_load_en, 16'h0001);
      check("flush", flush, 16'h0001);
      check("carry_we", carry_we, 16'h0000);
      step(14'h0000, 1'b0);
      #1 check("file_we", file_we, 16'h0000);
      check("carry_we", carry_we, 16'h0000);
      check("flush", flush, 16'h0000);
      $display("test_retlit done");
   endtask : test_retlit
   // plain return pops in reverse order; literal 0xFF at the top of range
   task test_return;
      push(13'h0ABC);
      push(13'h1F00);
      step(14'h0008, 1'b1);
      step(14'h0000, 1'b0);
      #1 check("pc_load", pc_load, 16'h1F00);
      check("pc_load_en", pc_load_en, 16'h0001);
      check("flush", flush, 16'h0001);
      check("acc", acc, 16'h0055);
      check("carry_we", carry_we, 16'h0000);
      step(14'h37FF, 1'b1);
      step(14'h0000, 1'b0);
      #1 check("pc_load", pc_load, 16'h0ABC);
      check("acc", acc, 16'h00FF);
      step(14'h0000, 1'b0);
      #1 check("pc_load_en", pc_load_en, 16'h0000);
      $display("test_return done");
   endtask : test_return
   // three rotates back to back: to acc, to file at address 127, to acc
   task test_rotate;
      step(14'h0D05, 1'b1);
      file_rdata <= 8'hE6;
      carry_in <= 1'b0;
      step(14'h0DFF, 1'b1);
      file_rdata <= 8'h81;
      carry_in <= 1'b1;
      #1 check("acc", acc, 16'h00CC);
      check("carry_out", carry_out, 16'h0001);
      check("carry_we", carry_we, 16'h0001);
      check("file_we", file_we, 16'h0000);
      step(14'h0D05, 1'b1);
      file_rdata <= 8'h40;
      carry_in <= 1'b0;
      #1 check("file_we", file_we, 16'h0001);
      check("file_addr", file_addr, 16'h007F);
      check("file_wdata", file_wdata, 16'h0003);
      check("acc", acc, 16'h00CC);
      check("carry_out", carry_out, 16'h0001);
      check("flush", flush, 16'h0000);
      step(14'h0000, 1'b0);
      #1 check("acc", acc, 16'h0080);
      check("carry_out", carry_out, 16'h0000);
      step(14'h0000, 1'b0);
      #1 check("carry_we", carry_we, 16'h0000);
      $display("test_rotate done");
   endtask : test_rotate
   ////////////////////////////////////////////////////////////////////////////////
   // refused words: rotate not offered, unknown word, return in the refill cycle
   task test_refuse;
      step(14'h0D05, 1'b0);
      file_rdata <= 8'h81;
      carry_in <= 1'b1;
      step(14'h0C85, 1'b1);
      #1 check("carry_we", carry_we, 16'h0000);
      check("acc", acc, 16'h0080);
      push(13'h0777);
      #1 check("file_we", file_we, 16'h0000);
      check("carry_we", carry_we, 16'h0000);
      step(14'h3412, 1'b1);
      step(14'h0008, 1'b1);
      #1 check("acc", acc, 16'h0012);
      check("pc_load", pc_load, 16'h0777);
      step(14'h0000, 1'b0);
      #1 check("pc_load_en", pc_load_en, 16'h0000);
      check("flush", flush, 16'h0000);
      $display("test_refuse done");
   endtask : test_refuse
   // reset in mid-run clears the outputs; the first word after release executes
   task test_reset;
      step(14'h0D85, 1'b1);
      rst <= 1'b1;
      step(14'h0D85, 1'b1);
      rst <= 1'b0;
      #1 check("acc", acc, 16'h0000);
      check("file_we", file_we, 16'h0000);
      step(14'h0000, 1'b0);
      #1 check("file_we", file_we, 16'h0001);
      check("file_addr", file_addr, 16'h0005);
      check("file_wdata", file_wdata, 16'h0003);
      check("carry_out", carry_out, 16'h0001);
      $display("test_reset done");
   endtask : test_reset
   // main sequence: five cycles of reset, then the tests
   initial begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      step(14'h0000, 1'b0);
      #1 check("acc", acc, 16'h0000);
      test_retlit();
      test_return();
      test_rotate();
      test_refuse();
      test_reset();
      end_sim();
   end
   // watchdog: the tests need well under a hundred cycles
   initial begin
      #(50 * 1000);
      fails++;
      end_sim();
   end
endmodule : test_return_and_rotate_exec
`default_nettype wire
